// file: verilog/cb_watchdog_pkg.sv
// Package: constants, register map and carriers for the balancing watchdog
package cb_watchdog_pkg;
   // =========================================================
   // Clock and timing
   // =========================================================
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned PRESCALE_BASE_S = 1;
   localparam int unsigned BASE_TICK_CYC   = CLK_HZ * PRESCALE_BASE_S;
   localparam int unsigned STARTUP_US      = 280;
   localparam int unsigned STARTUP_CYC     = (STARTUP_US * (CLK_HZ / 1_000_000));
   localparam logic [4:0]  PERIOD_SEL1_S   = 5'h01;
   localparam logic [4:0]  PERIOD_SEL2_S   = 5'h04;
   localparam logic [4:0]  PERIOD_SEL3_S   = 5'h10;

   // =========================================================
   // Register map
   // =========================================================
   localparam logic [7:0]  ADDR_DEVICE_STATUS     = 8'h02;
   localparam logic [7:0]  ADDR_ACQUISITION_CFG   = 8'h0C;
   localparam logic [15:0] RESET_ACQUISITION_CFG  = 16'h0000;
   localparam int unsigned RESET_FLAG_BIT         = 0;
   localparam int unsigned COUNT_LSB              = 8;
   localparam int unsigned PRESCALE_LSB           = 14;
   localparam logic [1:0]  PRESCALE_OFF           = 2'h0;
   localparam logic [3:0]  COUNT_ZERO             = 4'h0;
   localparam int unsigned NUM_SWITCHES           = 12;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } reg_req_t;

   typedef enum logic [0:0] {
      ST_WAIT_OSC = 1'b0,
      ST_ACTIVE   = 1'b1
   } power_state_t;
endpackage

// file: verilog/cell_balance_timeout_watchdog.sv
// Cell-balancing timeout watchdog with power-up sequencing and thermal gating
// Contract
// - Timeout is 4-bit down-counter, selectable prescale
// - Count and prescale live in config MSB
// - Decrement every 1, 4 or 16 seconds
// - Prescale 00 disables; nonzero starts countdown
// - Count RW; read returns acknowledge-time snapshot
// - Counting down to zero forces switches off until refresh
// - Separate gate; switch config left untouched
// - Only transition into zero disables switches
// - Oscillator first, logic after 280 us
// - Reset flag set on power return; host clears
// - Thermal shutdown gates switches, config untouched
// - Power-on reset returns registers to defaults
module cell_balance_timeout_watchdog
   import cb_watchdog_pkg::*;
#(
   parameter int unsigned TICK_CYC    = BASE_TICK_CYC,
   parameter int unsigned STARTUP_CNT = STARTUP_CYC
) (
   input  wire logic                    i_mclk,
   input  wire logic                    i_rst_n,
   input  wire logic                    i_ce,
   input  wire reg_req_t                i_req,
   input  wire logic                    i_ack_sample,
   input  wire logic                    i_thermal_shutdown,
   input  wire logic [NUM_SWITCHES-1:0] i_balance_switch_config,
   output logic [15:0]                  o_reg_rdata,
   output logic                         o_osc_enable,
   output logic                         o_logic_enable,
   output logic                         o_charge_pump_enable,
   output logic [NUM_SWITCHES-1:0]      o_balance_switch_en
);
   // =========================================================
   // Pin synchronisers
   // =========================================================
   logic [2:0]   ack_sync;
   logic [2:0]   therm_sync;
   logic         ack_level;
   logic         ack_prev;
   logic         therm_level;
   logic         ack_strobe;

   // Third stage must agree with second before a change is accepted
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_sync    <= 3'h0;
         therm_sync  <= 3'h0;
         ack_level   <= 1'b0;
         ack_prev    <= 1'b0;
         therm_level <= 1'b0;
      end else if (i_ce) begin
         ack_sync   <= {ack_sync[1:0], i_ack_sample};
         therm_sync <= {therm_sync[1:0], i_thermal_shutdown};
         if (ack_sync[1] == ack_sync[2]) begin
            ack_level <= ack_sync[2];
         end
         if (therm_sync[1] == therm_sync[2]) begin
            therm_level <= therm_sync[2];
         end
         ack_prev <= ack_level;
      end
   end
   assign ack_strobe = ack_level & ~ack_prev;

   // =========================================================
   // Power-up sequencing
   // =========================================================
   power_state_t pstate;
   logic [31:0]  startup_cnt;
   logic         flag_set;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pstate      <= ST_WAIT_OSC;
         startup_cnt <= 32'h0;
      end else if (i_ce) begin
         case (pstate)
            ST_WAIT_OSC: begin
               if (startup_cnt == STARTUP_CNT - 1) begin
                  pstate <= ST_ACTIVE;
               end else begin
                  startup_cnt <= startup_cnt + 32'h1;
               end
            end
            ST_ACTIVE: pstate <= ST_ACTIVE;
            default:   pstate <= ST_WAIT_OSC;
         endcase
      end
   end
   assign o_osc_enable         = 1'b1;
   assign o_logic_enable       = (pstate == ST_ACTIVE);
   assign o_charge_pump_enable = (pstate == ST_ACTIVE);
   assign flag_set = i_ce && (pstate == ST_WAIT_OSC) && (startup_cnt == STARTUP_CNT - 1);

   // =========================================================
   // Registers
   // =========================================================
   logic         wr_acq;
   logic         wr_stat;
   logic [15:0]  acq_low;
   logic [1:0]   prescale_sel;
   logic [3:0]   count;
   logic [3:0]   count_snap;
   logic         reset_flag;
   logic         dec_pulse;

   assign wr_acq  = i_ce && o_logic_enable && i_req.wr && (i_req.addr == ADDR_ACQUISITION_CFG);
   assign wr_stat = i_ce && o_logic_enable && i_req.wr && (i_req.addr == ADDR_DEVICE_STATUS);

   // Bits of the config word outside the watchdog fields are plain storage
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         acq_low      <= RESET_ACQUISITION_CFG;
         prescale_sel <= RESET_ACQUISITION_CFG[PRESCALE_LSB +: 2];
      end else if (wr_acq) begin
         acq_low      <= i_req.wdata;
         prescale_sel <= i_req.wdata[PRESCALE_LSB +: 2];
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count <= RESET_ACQUISITION_CFG[COUNT_LSB +: 4];
      end else if (wr_acq) begin
         count <= i_req.wdata[COUNT_LSB +: 4];
      end else if (dec_pulse && count != COUNT_ZERO) begin
         count <= count - 4'h1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_snap <= COUNT_ZERO;
      end else if (i_ce && ack_strobe) begin
         count_snap <= count;
      end
   end

   // Write-one-to-clear; a set in the same cycle wins
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         reset_flag <= 1'b0;
      end else if (flag_set) begin
         reset_flag <= 1'b1;
      end else if (wr_stat && i_req.wdata[RESET_FLAG_BIT]) begin
         reset_flag <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata <= 16'h0000;
      end else if (i_ce && i_req.rd) begin
         case (i_req.addr)
            ADDR_ACQUISITION_CFG: begin
               o_reg_rdata                         <= acq_low;
               o_reg_rdata[PRESCALE_LSB +: 2]      <= prescale_sel;
               o_reg_rdata[COUNT_LSB +: 4]         <= count_snap;
            end
            ADDR_DEVICE_STATUS: begin
               o_reg_rdata                 <= 16'h0000;
               o_reg_rdata[RESET_FLAG_BIT] <= reset_flag;
            end
            default: o_reg_rdata <= 16'h0000;
         endcase
      end
   end

   // =========================================================
   // Prescaler
   // =========================================================
   logic [31:0]  tick_cnt;
   logic [4:0]   sec_cnt;
   logic [4:0]   period_s;
   logic         sec_tick;

   always_comb begin
      case (prescale_sel)
         2'h1:    period_s = PERIOD_SEL1_S;
         2'h2:    period_s = PERIOD_SEL2_S;
         2'h3:    period_s = PERIOD_SEL3_S;
         default: period_s = PERIOD_SEL1_S;
      endcase
   end

   assign sec_tick  = (tick_cnt == TICK_CYC - 1);
   assign dec_pulse = i_ce && !wr_acq && (prescale_sel != PRESCALE_OFF) && sec_tick && (sec_cnt == period_s - 5'h1);

   // Phase restarts on every config write so a refresh buys a full period
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_cnt <= 32'h0;
         sec_cnt  <= 5'h00;
      end else if (i_ce) begin
         if (wr_acq || prescale_sel == PRESCALE_OFF) begin
            tick_cnt <= 32'h0;
            sec_cnt  <= 5'h00;
         end else if (sec_tick) begin
            tick_cnt <= 32'h0;
            sec_cnt  <= (sec_cnt == period_s - 5'h1) ? 5'h00 : sec_cnt + 5'h01;
         end else begin
            tick_cnt <= tick_cnt + 32'h1;
         end
      end
   end

   // =========================================================
   // Timeout gate and switch outputs
   // =========================================================
   logic         timed_out;
   logic         switch_gate;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         timed_out <= 1'b0;
      end else if (i_ce) begin
         if (prescale_sel == PRESCALE_OFF) begin
            timed_out <= 1'b0;
         end else if (wr_acq) begin
            // Writing zero with a nonzero prescale neither trips nor clears: only a decrement trips
            if (i_req.wdata[COUNT_LSB +: 4] != COUNT_ZERO || i_req.wdata[PRESCALE_LSB +: 2] == PRESCALE_OFF) begin
               timed_out <= 1'b0;
            end
         end else if (dec_pulse && count == 4'h1) begin
            timed_out <= 1'b1;
         end
      end
   end

   // Balancing config is only masked here, never rewritten
   assign switch_gate = timed_out | therm_level;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_balance_switch_en <= '0;
      end else if (i_ce) begin
         o_balance_switch_en <= i_balance_switch_config & {NUM_SWITCHES{~switch_gate}};
      end
   end

   // =========================================================
   // Assertions
   // =========================================================
   sequence s_cfg_refresh;
      wr_acq && i_req.wdata[COUNT_LSB +: 4] != COUNT_ZERO;
   endsequence
   sequence s_last_decrement;
      dec_pulse && count == 4'h1 && prescale_sel != PRESCALE_OFF;
   endsequence

   switch_mask_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_rst_n |=> o_balance_switch_en == ($past(i_balance_switch_config) & {NUM_SWITCHES{~$past(switch_gate)}}))
      else $error("switch enables do not follow config and gate");
   thermal_gate_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && therm_level |=> o_balance_switch_en == '0)
      else $error("switches on during thermal shutdown");
   trip_on_zero_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      s_last_decrement |=> timed_out && count == COUNT_ZERO)
      else $error("reaching zero did not trip timeout");
   zero_enable_safe_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      wr_acq && !timed_out |=> !timed_out)
      else $error("write tripped the timeout");
   refresh_clears_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      s_cfg_refresh |=> !timed_out && count == $past(i_req.wdata[COUNT_LSB +: 4]))
      else $error("nonzero refresh did not clear timeout");
   disable_clears_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && prescale_sel == PRESCALE_OFF |=> !timed_out && tick_cnt == 32'h0)
      else $error("disabled timer still running");
   count_step_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      dec_pulse && count != COUNT_ZERO |=> count == $past(count) - 4'h1)
      else $error("count did not step by one");
   write_phase_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      wr_acq |=> tick_cnt == 32'h0 && sec_cnt == 5'h00)
      else $error("write did not restart prescaler");
   startup_wait_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $rose(o_logic_enable) |-> $past(startup_cnt) == STARTUP_CNT - 1 && reset_flag)
      else $error("logic enabled early or flag missing");
   snapshot_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && ack_strobe |=> count_snap == $past(count))
      else $error("acknowledge snapshot wrong");
endmodule

// file: tb/host_model.sv
// Host controller model: register accesses and read-all acknowledge timing
module host_model
   import cb_watchdog_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic [15:0] i_rdata,
   output reg_req_t         o_req,
   output logic             o_ack_sample
);
   timeunit 1ns;
   timeprecision 1ps;

   // =========================================================
   // Bus and link state
   // =========================================================
   // Link clock stands still outside read-all frames
   logic lclk;

   initial begin
      o_req = '0;
      o_ack_sample = 1'b0;
      lclk = 1'b0;
   end

   // =========================================================
   // Accesses
   // =========================================================
   // Register write: request held for one clock edge, then dropped
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_mclk);
      o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_mclk);
      o_req <= '0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge i_mclk);
      o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge i_mclk);
      o_req <= '0;
      #1 d = i_rdata;
   endtask

   // Acknowledge after the address byte, two link periods in
   task automatic ack_frame();
      // Offset keeps the pin change off the sampling edge
      #5;
      repeat (2) begin
         #80 lclk = 1'b1;
         #80 lclk = 1'b0;
      end
      o_ack_sample = 1'b1;
      #320 o_ack_sample = 1'b0;
   endtask
endmodule

// file: tb/cell_balance_timeout_watchdog_test.sv
// Testbench for the balancing timeout watchdog
module cell_balance_timeout_watchdog_test
   import cb_watchdog_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // =========================================================
   // Signals
   // =========================================================
   // Short counts keep the run small
   localparam int unsigned TICK = 10;
   localparam int unsigned STUP = 8;
   localparam logic [11:0] CFG  = 12'hA5C;
   logic                    i_mclk, i_rst_n, i_ce, i_thermal_shutdown, ack;
   logic [NUM_SWITCHES-1:0] i_balance_switch_config, o_balance_switch_en;
   logic                    o_osc_enable, o_logic_enable, o_charge_pump_enable;
   logic [15:0]             o_reg_rdata, d;
   logic [1:0]              s;
   reg_req_t                req;
   int                      n_mismatch, n_compared;
   int                      per[3] = '{1, 4, 16};

   cell_balance_timeout_watchdog #(.TICK_CYC(TICK), .STARTUP_CNT(STUP)) DUT (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req(req),
      .i_ack_sample(ack), .i_thermal_shutdown(i_thermal_shutdown),
      .i_balance_switch_config(i_balance_switch_config), .o_reg_rdata(o_reg_rdata),
      .o_osc_enable(o_osc_enable), .o_logic_enable(o_logic_enable),
      .o_charge_pump_enable(o_charge_pump_enable), .o_balance_switch_en(o_balance_switch_en));

   host_model u_host (.i_mclk(i_mclk), .i_rdata(o_reg_rdata), .o_req(req), .o_ack_sample(ack));

   always #10 i_mclk = ~i_mclk;

   // =========================================================
   // Tasks
   // =========================================================
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
   endtask

   // Let the edge's updates land before looking
   task automatic sw_chk(input logic on);
      #1 chk({4'h0, o_balance_switch_en}, on ? {4'h0, CFG} : 16'h0000);
   endtask

   task automatic test_done();
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #50us;
      n_mismatch++;
      test_done();
   end

   // =========================================================
   // Tests
   // =========================================================
   initial begin
      i_mclk = 1'b0;
      i_rst_n = 1'b0;
      i_ce = 1'b1;
      i_thermal_shutdown = 1'b0;
      i_balance_switch_config = CFG;
      n_mismatch = 0;
      n_compared = 0;
      cyc(6);
      chk({15'h0, o_osc_enable}, 16'h0001);
      i_rst_n <= 1'b1;
      u_host.wr(ADDR_ACQUISITION_CFG, 16'h4F00);
      #1 chk({14'h0, o_logic_enable, o_charge_pump_enable}, 16'h0000);
      cyc(STUP);
      #1 chk({14'h0, o_logic_enable, o_charge_pump_enable}, 16'h0003);
      u_host.rd(ADDR_ACQUISITION_CFG, d);
      chk(d, 16'h0000);
      u_host.rd(ADDR_DEVICE_STATUS, d);
      chk(d, 16'h0001);
      u_host.wr(ADDR_DEVICE_STATUS, 16'h0001);
      u_host.rd(ADDR_DEVICE_STATUS, d);
      chk(d, 16'h0000);
      u_host.rd(8'h05, d);
      chk(d, 16'h0000);
      sw_chk(1'b1);
      // Each prescale setting, count 1; each write also clears the trip
      for (int i = 0; i < 3; i++) begin
         s = 2'(i + 1);
         u_host.wr(ADDR_ACQUISITION_CFG, {s, 2'h0, 4'h1, 8'h00});
         cyc(2);
         sw_chk(1'b1);
         cyc(TICK * per[i] - 4);
         sw_chk(1'b1);
         cyc(4);
         sw_chk(1'b0);
      end
      cyc(20);
      sw_chk(1'b0);
      u_host.wr(ADDR_ACQUISITION_CFG, 16'h0100);
      cyc(2);
      sw_chk(1'b1);
      cyc(20);
      sw_chk(1'b1);
      u_host.wr(ADDR_ACQUISITION_CFG, 16'h4000);
      cyc(30);
      sw_chk(1'b1);
      // Snapshot taken mid-period must not follow the live count
      u_host.wr(ADDR_ACQUISITION_CFG, 16'h8500);
      cyc(45);
      u_host.ack_frame();
      cyc(2);
      u_host.rd(ADDR_ACQUISITION_CFG, d);
      chk(d, 16'h8400);
      cyc(1);
      i_thermal_shutdown <= 1'b1;
      cyc(6);
      sw_chk(1'b0);
      cyc(1);
      i_thermal_shutdown <= 1'b0;
      cyc(6);
      sw_chk(1'b1);
      cyc(1);
      i_rst_n <= 1'b0;
      cyc(2);
      i_rst_n <= 1'b1;
      cyc(STUP + 4);
      u_host.rd(ADDR_ACQUISITION_CFG, d);
      chk(d, 16'h0000);
      u_host.rd(ADDR_DEVICE_STATUS, d);
      chk(d, 16'h0001);
      // Clock enable low must freeze the countdown
      u_host.wr(ADDR_ACQUISITION_CFG, 16'h4100);
      i_ce <= 1'b0;
      cyc(20);
      i_ce <= 1'b1;
      sw_chk(1'b1);
      cyc(12);
      sw_chk(1'b0);
      test_done();
   end
endmodule
